// ===== rtl/vext_cfg.svh
// constants for the vector extension enable and gating block
`ifndef VEXT_CFG_SVH
`define VEXT_CFG_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define OFF_FEAT_ENABLE   12'h000
`define OFF_CTRL          12'h004
`define OFF_ID_LEAF1      12'h008
`define OFF_INT_STATUS    12'h00C
`define OFF_INT_ENABLE    12'h010
`define OFF_INT_CLEAR     12'h014
`define OFF_LAST_CHECK    12'h018
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FE_NARROW_BIT     1
`define FE_WIDE_BIT       2
`define FE_X87_BIT        0
`define ID_CLMUL_BIT      1
`define ID_CIPHER_BIT     25
`define ID_SAVE_BIT       26
`define ID_OSSAVE_BIT     27
`define ID_WIDE_BIT       28
`define CTRL_EMUL_BIT     0
`define CTRL_HANDLER_BIT  1
`define CTRL_OSSAVE_BIT   2
`define CTRL4_HANDLER_POS 10
// interrupt status bits
`define IRQ_UD_BIT        0
`define IRQ_XM_BIT        1
`define IRQ_WRFAULT_BIT   2
`define IRQ_W             3
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define FEAT_ENABLE_RST   32'h0000_0001
`define CTRL_RST          32'h0000_0000
`endif

// ===== rtl/vext_pkg.sv
// types for the vector extension enable and gating block
`default_nettype none
package vext_pkg;
    // class of an instruction offered to the gate
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_WIDE,       // plain vector-prefixed wide instruction
        CLS_CIPHER,     // vector-prefixed cipher round family
        CLS_CLMUL,      // vector-prefixed carry-less multiply
        CLS_LEGACY_FP,  // legacy simd floating-point
        CLS_CTRL_READ,  // extended-control read
        CLS_CTRL_WRITE  // extended-control write
    } instr_class_t;
    // outcome of one check
    typedef enum logic [1:0] {
        OUT_ALLOW,
        OUT_UD,
        OUT_EMUL,
        OUT_GP
    } outcome_t;
endpackage
`default_nettype wire

// ===== rtl/vext_sync.sv
// three-stage synchroniser with agreement check for pin inputs
`default_nettype none
module vext_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic s1_ff;     // first stage, read only by s2
    logic s2_ff;
    logic s3_ff;
    // ---------------------------------------------------------------
    // shift chain
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else if (ce_i) begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // ---------------------------------------------------------------
    // output moves only once stages two and three agree
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (ce_i && (s2_ff == s3_ff)) begin
            level_o <= s3_ff;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/vext_gate.sv
// combinational gate deciding one instruction's outcome
`default_nettype none
`include "vext_cfg.svh"
module vext_gate (
    input  wire vext_pkg::instr_class_t cls_i,
    input  wire logic [31:0]            feat_i,
    input  wire logic [31:0]            id_i,
    input  wire logic                   emul_i,
    input  wire logic                   priv0_i,
    output vext_pkg::outcome_t          out_o
);
    logic wide_ok;   // single combined enable for wide state
    // both register states enabled plus hardware wide support and os save flag
    assign wide_ok = feat_i[`FE_WIDE_BIT] & feat_i[`FE_NARROW_BIT]
                   & id_i[`ID_WIDE_BIT] & id_i[`ID_OSSAVE_BIT];
    // ---------------------------------------------------------------
    // decision per class
    // ---------------------------------------------------------------
    always_comb begin
        out_o = vext_pkg::OUT_ALLOW;
        case (cls_i)
            vext_pkg::CLS_WIDE: begin
                // emulation bit gives no escape for wide ops
                if (!wide_ok) out_o = vext_pkg::OUT_UD;
            end
            vext_pkg::CLS_CIPHER: begin
                if (!(wide_ok && id_i[`ID_CIPHER_BIT]))
                    out_o = vext_pkg::OUT_UD;
            end
            vext_pkg::CLS_CLMUL: begin
                if (!(wide_ok && id_i[`ID_CLMUL_BIT]))
                    out_o = vext_pkg::OUT_UD;
            end
            vext_pkg::CLS_LEGACY_FP: begin
                // legacy simd only may go to software emulation
                if (emul_i) out_o = vext_pkg::OUT_EMUL;
            end
            vext_pkg::CLS_CTRL_READ: begin
                if (!id_i[`ID_OSSAVE_BIT])
                    out_o = vext_pkg::OUT_UD;
            end
            vext_pkg::CLS_CTRL_WRITE: begin
                if (!id_i[`ID_OSSAVE_BIT]) out_o = vext_pkg::OUT_UD;
                else if (!priv0_i) out_o = vext_pkg::OUT_GP;
            end
            default: out_o = vext_pkg::OUT_ALLOW;
        endcase
    end
endmodule
`default_nettype wire

// ===== rtl/vext_enable_gating.sv
// vector extension feature reporting and enable gating, apb slave
//
// How it works
// - leaf1 bit27 shows os enabled control read
// - control read returns feature enable register
// - leaf1 bit28 shows wide hardware support
// - os save flag implies save instructions present
// - control write only at privilege zero
// - wide ops fault when os disabled
// - leaf1 bit26 shows hardware save only
// - cipher ops need bit25 plus wide enable
// - carry-less multiply needs bit1 plus enable
// - emulation bit never covers wide ops
// - clearing enable bits 2:1 faults wide ops
// - wide fp exceptions handled like legacy
// - no handler flag turns fp fault undefined
`default_nettype none
`include "vext_cfg.svh"
module vext_enable_gating (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic [31:0]      prdata_o,
    // hardware capability straps from pins
    input  wire logic        hw_wide_i,
    input  wire logic        hw_save_i,
    input  wire logic        hw_cipher_i,
    input  wire logic        hw_clmul_i,
    // decoder side, same clock
    input  wire logic        dec_valid_i,
    input  wire logic [2:0]  dec_class_i,
    input  wire logic        dec_priv0_i,
    input  wire logic [31:0] dec_wdata_i,
    input  wire logic        dec_fp_exc_i,
    input  wire logic        dec_fp_masked_i,
    output logic             dec_ud_o,
    output logic             dec_gp_o,
    output logic             dec_emul_o,
    output logic             dec_xm_o,
    output logic             dec_commit_o,
    output logic [31:0]      dec_rdata_o,
    output logic [31:0]      id_leaf1_o,
    output logic [31:0]      ctrl4_o,
    output logic             irq_o
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0]          feat_ff;       // feature enable register
    logic [31:0]          ctrl_ff;       // os control bits
    logic [`IRQ_W-1:0]    sts_ff;        // sticky events
    logic [`IRQ_W-1:0]    ien_ff;        // event enables
    logic [7:0]           last_ff;       // last outcome and class
    logic                 hw_wide;       // synchronised straps
    logic                 hw_save;
    logic                 hw_cipher;
    logic                 hw_clmul;
    logic [31:0]          id_word;       // assembled leaf1 result
    vext_pkg::instr_class_t cls;
    vext_pkg::outcome_t   outc;
    logic                 os_save;
    logic                 apb_wr;
    logic                 apb_rd;
    logic                 dec_wr_ok;
    logic [`IRQ_W-1:0]    ev;            // event pulses this cycle
    logic [`IRQ_W-1:0]    clr;           // software clear mask
    logic                 hit;           // address is mapped
    logic                 xm_unmasked;

    // ---------------------------------------------------------------
    // straps come from pins, so each passes a synchroniser
    // ---------------------------------------------------------------
    logic [3:0] strap_pin;
    logic [3:0] strap_lvl;
    assign strap_pin = {hw_clmul_i, hw_cipher_i, hw_save_i, hw_wide_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            vext_sync u_sync (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .ce_i    (ce_i),
                .pin_i   (strap_pin[gi]),
                .level_o (strap_lvl[gi])
            );
        end
    endgenerate
    assign hw_wide   = strap_lvl[0];
    assign hw_save   = strap_lvl[1];
    assign hw_cipher = strap_lvl[2];
    assign hw_clmul  = strap_lvl[3];

    // os save flag only honoured when the save hardware exists
    assign os_save = ctrl_ff[`CTRL_OSSAVE_BIT] & hw_save;

    // ---------------------------------------------------------------
    // identification leaf 1 word
    // ---------------------------------------------------------------
    always_comb begin
        id_word = 32'h0000_0000;
        id_word[`ID_CLMUL_BIT]  = hw_clmul;
        id_word[`ID_CIPHER_BIT] = hw_cipher;
        // hardware only, says nothing of os use
        id_word[`ID_SAVE_BIT]   = hw_save;
        id_word[`ID_OSSAVE_BIT] = os_save;
        id_word[`ID_WIDE_BIT]   = hw_wide;
    end

    // control register 4 image, handler flag at bit 10
    always_comb begin
        ctrl4_o = 32'h0000_0000;
        ctrl4_o[`CTRL4_HANDLER_POS] = ctrl_ff[`CTRL_HANDLER_BIT];
    end

    // ---------------------------------------------------------------
    // gate for the current decoded instruction
    // ---------------------------------------------------------------
    assign cls = dec_valid_i ? vext_pkg::instr_class_t'(dec_class_i)
                             : vext_pkg::CLS_NONE;
    vext_gate u_gate (
        .cls_i   (cls),
        .feat_i  (feat_ff),
        .id_i    (id_word),
        .emul_i  (ctrl_ff[`CTRL_EMUL_BIT]),
        .priv0_i (dec_priv0_i),
        .out_o   (outc)
    );

    // fault flags are combinational so they precede any commit
    assign dec_ud_o   = (outc == vext_pkg::OUT_UD)
                      | (dec_valid_i & xm_unmasked
                         & ~ctrl_ff[`CTRL_HANDLER_BIT]);
    assign dec_gp_o   = (outc == vext_pkg::OUT_GP);
    assign dec_emul_o = (outc == vext_pkg::OUT_EMUL);
    // fp exceptions for wide and legacy share one path
    assign xm_unmasked = dec_fp_exc_i & ~dec_fp_masked_i
                       & ((cls == vext_pkg::CLS_WIDE)
                          | (cls == vext_pkg::CLS_CIPHER)
                          | (cls == vext_pkg::CLS_CLMUL)
                          | (cls == vext_pkg::CLS_LEGACY_FP));
    assign dec_xm_o = dec_valid_i & xm_unmasked
                    & ctrl_ff[`CTRL_HANDLER_BIT];
    // commit only when no fault of any kind stands
    assign dec_commit_o = dec_valid_i & ~dec_ud_o & ~dec_gp_o
                        & ~dec_emul_o & ~dec_xm_o;
    assign dec_wr_ok = dec_commit_o & (cls == vext_pkg::CLS_CTRL_WRITE);

    // ---------------------------------------------------------------
    // decoder read data, registered
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dec_rdata_o <= 32'h0000_0000;
            id_leaf1_o  <= 32'h0000_0000;
        end else if (ce_i) begin
            id_leaf1_o <= id_word;
            // control read hands back the feature enable word
            if (dec_commit_o && cls == vext_pkg::CLS_CTRL_READ) begin
                dec_rdata_o <= feat_ff;
            end
        end
    end

    // ---------------------------------------------------------------
    // apb decode, zero wait state
    // ---------------------------------------------------------------
    assign pready_o = 1'b1;
    always_comb begin
        case (paddr_i)
            `OFF_FEAT_ENABLE, `OFF_CTRL, `OFF_ID_LEAF1, `OFF_INT_STATUS,
            `OFF_INT_ENABLE, `OFF_INT_CLEAR, `OFF_LAST_CHECK: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign apb_wr = psel_i & penable_i & pwrite_i & hit;
    assign apb_rd = psel_i & penable_i & ~pwrite_i & hit;

    // ---------------------------------------------------------------
    // feature enable register, written by privileged control write
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            feat_ff <= `FEAT_ENABLE_RST;
        end else if (ce_i) begin
            if (dec_wr_ok) begin
                // bit 0 always stays set, upper bits unimplemented
                feat_ff <= {29'h0, dec_wdata_i[2:1], 1'b1};
            end else if (apb_wr && paddr_i == `OFF_FEAT_ENABLE) begin
                // os may clear 2:1 to emulate wide ops itself
                feat_ff <= {29'h0, pwdata_i[2:1], 1'b1};
            end
        end
    end

    // ---------------------------------------------------------------
    // os control bits
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_ff <= `CTRL_RST;
        end else if (ce_i) begin
            if (apb_wr && paddr_i == `OFF_CTRL) begin
                ctrl_ff <= {29'h0, pwdata_i[2:0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status, set wins over clear
    // ---------------------------------------------------------------
    always_comb begin
        ev = '0;
        ev[`IRQ_UD_BIT]      = dec_ud_o;
        ev[`IRQ_XM_BIT]      = dec_xm_o;
        ev[`IRQ_WRFAULT_BIT] = dec_gp_o;
        clr = '0;
        if (apb_wr && paddr_i == `OFF_INT_CLEAR) clr = pwdata_i[`IRQ_W-1:0];
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sts_ff <= '0;
        end else if (ce_i) begin
            sts_ff <= (sts_ff & ~clr) | ev;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ien_ff <= '0;
        end else if (ce_i && apb_wr && paddr_i == `OFF_INT_ENABLE) begin
            ien_ff <= pwdata_i[`IRQ_W-1:0];
        end
    end
    assign irq_o = |(sts_ff & ien_ff);

    // last checked class and outcome for software debug
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            last_ff <= 8'h00;
        end else if (ce_i && dec_valid_i) begin
            last_ff <= {3'h0, outc, cls};
        end
    end

    // ---------------------------------------------------------------
    // apb read data, registered at the setup-phase edge
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (ce_i && psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `OFF_FEAT_ENABLE: prdata_o <= feat_ff;
                `OFF_CTRL:        prdata_o <= ctrl_ff;
                `OFF_ID_LEAF1:    prdata_o <= id_word;
                `OFF_INT_STATUS:  prdata_o <= {29'h0, sts_ff};
                `OFF_INT_ENABLE:  prdata_o <= {29'h0, ien_ff};
                `OFF_LAST_CHECK:  prdata_o <= {24'h0, last_ff};
                default:          prdata_o <= 32'h0000_0000;
            endcase
        end
    end
    // apb_rd kept for symmetry of decode; reads have no side effect
    logic unused_rd;
    assign unused_rd = apb_rd;
endmodule
`default_nettype wire

// ===== verif/vext_enable_gating_asserts.sv
// port-level assertions for the vector extension gating block
`default_nettype none
module vext_enable_gating_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pslverr_o,
    input wire logic        dec_valid_i,
    input wire logic [2:0]  dec_class_i,
    input wire logic        dec_priv0_i,
    input wire logic        dec_fp_exc_i,
    input wire logic        dec_fp_masked_i,
    input wire logic        dec_ud_o,
    input wire logic        dec_gp_o,
    input wire logic        dec_emul_o,
    input wire logic        dec_xm_o,
    input wire logic        dec_commit_o,
    input wire logic [31:0] dec_rdata_o,
    input wire logic [31:0] id_leaf1_o,
    input wire logic [31:0] ctrl4_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // one clock domain
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // an offered op of class c that went through
    sequence s_commit(logic [2:0] c);
        dec_valid_i && dec_class_i == c && dec_commit_o;
    endsequence
    // leaf word lags the gate by one cycle, so flags are seen next edge
    property p_wide_flags;
        s_commit(3'h1) |=> id_leaf1_o[27] && id_leaf1_o[28];
    endproperty
    a_wide_flags: assert property (p_wide_flags)
        else $error("wide op passed without os and hw flags");
    property p_cipher_flags;
        s_commit(3'h2) |=> id_leaf1_o[25] && id_leaf1_o[27] && id_leaf1_o[28];
    endproperty
    a_cipher_flags: assert property (p_cipher_flags)
        else $error("cipher op passed without its flags");
    property p_clmul_flags;
        s_commit(3'h3) |=> id_leaf1_o[1] && id_leaf1_o[27] && id_leaf1_o[28];
    endproperty
    a_clmul_flags: assert property (p_clmul_flags)
        else $error("carry-less op passed without its flags");
    property p_wr_priv;
        s_commit(3'h6) |-> dec_priv0_i ##1 id_leaf1_o[27];
    endproperty
    a_wr_priv: assert property (p_wr_priv)
        else $error("control write passed outside level zero");
    // bit0 is fixed, only bits 2:1 are live
    property p_rd_word;
        s_commit(3'h5) |=> dec_rdata_o[0] && dec_rdata_o[31:3] == 29'h0;
    endproperty
    a_rd_word: assert property (p_rd_word)
        else $error("control read word malformed");
    property p_fault_block;
        dec_valid_i && (dec_ud_o || dec_gp_o) |-> !dec_commit_o;
    endproperty
    a_fault_block: assert property (p_fault_block)
        else $error("faulting op also committed");
    property p_emul_legacy;
        dec_emul_o |-> dec_valid_i && dec_class_i == 3'h4;
    endproperty
    a_emul_legacy: assert property (p_emul_legacy)
        else $error("emulation offered to a non-legacy op");
    property p_xm_handler;
        dec_xm_o |-> ctrl4_o[10] && dec_fp_exc_i && !dec_fp_masked_i;
    endproperty
    a_xm_handler: assert property (p_xm_handler)
        else $error("simd fault raised without its cause");
    property p_no_handler;
        dec_valid_i && dec_fp_exc_i && !dec_fp_masked_i && !ctrl4_o[10]
            |-> !dec_xm_o;
    endproperty
    a_no_handler: assert property (p_no_handler)
        else $error("simd fault raised with no handler flag");
    property p_save_implied;
        id_leaf1_o[27] |-> id_leaf1_o[26];
    endproperty
    a_save_implied: assert property (p_save_implied)
        else $error("os save flag without save support");
    property p_slverr;
        pslverr_o |-> psel_i && penable_i;
    endproperty
    a_slverr: assert property (p_slverr)
        else $error("bus error outside access phase");
endmodule
`default_nettype wire

// ===== verif/vext_enable_gating_tb.sv
// self-checking bench for the vector extension gating block
`default_nettype none
module vext_enable_gating_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // outcome codes {ud, gp, emul, xm, commit}
    localparam logic [4:0] UD = 5'h10, GP = 5'h08, EM = 5'h04;
    localparam logic [4:0] XM = 5'h02, OK = 5'h01;
    logic        clk_i, rst_i, ce_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, dec_wdata_i, dec_rdata_o;
    logic [31:0] id_leaf1_o, ctrl4_o;
    logic        pready_o, pslverr_o, irq_o;
    logic        hw_wide_i, hw_save_i, hw_cipher_i, hw_clmul_i;
    logic        dec_valid_i, dec_priv0_i, dec_fp_exc_i, dec_fp_masked_i;
    logic [2:0]  dec_class_i;
    logic        dec_ud_o, dec_gp_o, dec_emul_o, dec_xm_o, dec_commit_o;
    int          err_count, n_checks, cycles;
    vext_enable_gating u_vext_enable_gating (.*);
    // ---------------------------------------------------------------
    // clock, timeout and reporting
    // ---------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // generous ceiling: the sequence needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // ---------------------------------------------------------------
    // bus and decoder drivers
    // ---------------------------------------------------------------
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, a, d, rd, e);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, a, 32'h0, rd, e);
        check(rd, exp);
        check({31'h0, e}, 32'h0);
    endtask
    // single-cycle offer, flags judged mid-cycle where they are settled
    task automatic op(input logic [2:0] c, input logic p,
                      input logic [31:0] w, input logic [1:0] fx,
                      input logic [4:0] exp);
        @(posedge clk_i);
        dec_valid_i <= 1'b1;
        dec_class_i <= c;
        dec_priv0_i <= p;
        dec_wdata_i <= w;
        dec_fp_exc_i <= fx[1];
        dec_fp_masked_i <= fx[0];
        @(negedge clk_i);
        check({27'h0, dec_ud_o, dec_gp_o, dec_emul_o, dec_xm_o,
               dec_commit_o}, {27'h0, exp});
        @(posedge clk_i);
        dec_valid_i <= 1'b0;
        dec_fp_exc_i <= 1'b0;
        @(negedge clk_i);
    endtask
    task automatic irq_chk(input logic exp);
        @(negedge clk_i);
        check({31'h0, irq_o}, {31'h0, exp});
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic        e;
        rd_chk(12'h000, 32'h0000_0001);
        rd_chk(12'h004, 32'h0000_0000);
        rd_chk(12'h00C, 32'h0000_0000);
        irq_chk(1'b0);
        apb(1'b0, 12'h01C, 32'h0, rd, e);
        check({rd[30:0], e}, 32'h0000_0001);
    endtask
    task automatic t_leaf1();
        repeat (8) @(posedge clk_i);
        rd_chk(12'h008, 32'h1600_0000);
        op(3'h6, 1'b1, 32'h7, 2'b00, UD);
        op(3'h1, 1'b0, 32'h0, 2'b00, UD);
        wr(12'h004, 32'h0000_0004);
        rd_chk(12'h008, 32'h1E00_0000);
        check(id_leaf1_o, 32'h1E00_0000);
    endtask
    task automatic t_gating();
        op(3'h1, 1'b0, 32'h0, 2'b00, UD);
        op(3'h5, 1'b0, 32'h0, 2'b00, OK);
        check(dec_rdata_o, 32'h0000_0001);
        wr(12'h000, 32'h0000_0006);
        rd_chk(12'h000, 32'h0000_0007);
        op(3'h1, 1'b0, 32'h0, 2'b00, OK);
        op(3'h2, 1'b0, 32'h0, 2'b00, OK);
        op(3'h3, 1'b0, 32'h0, 2'b00, UD);
        @(posedge clk_i) hw_clmul_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        op(3'h3, 1'b0, 32'h0, 2'b00, OK);
        op(3'h5, 1'b0, 32'h0, 2'b00, OK);
        check(dec_rdata_o, 32'h0000_0007);
        wr(12'h004, 32'h0000_0005);
        op(3'h1, 1'b0, 32'h0, 2'b00, OK);
        op(3'h4, 1'b0, 32'h0, 2'b00, EM);
        wr(12'h004, 32'h0000_0004);
        op(3'h4, 1'b0, 32'h0, 2'b00, OK);
        wr(12'h000, 32'h0000_0002);
        op(3'h1, 1'b0, 32'h0, 2'b00, UD);
        op(3'h2, 1'b0, 32'h0, 2'b00, UD);
        wr(12'h000, 32'h0000_0006);
    endtask
    task automatic t_ctrl_wr();
        op(3'h6, 1'b0, 32'h1, 2'b00, GP);
        op(3'h6, 1'b1, 32'h1, 2'b00, OK);
        rd_chk(12'h000, 32'h0000_0001);
        op(3'h1, 1'b0, 32'h0, 2'b00, UD);
        op(3'h6, 1'b1, 32'h6, 2'b00, OK);
        rd_chk(12'h000, 32'h0000_0007);
    endtask
    task automatic t_fp();
        op(3'h1, 1'b0, 32'h0, 2'b10, UD);
        wr(12'h004, 32'h0000_0006);
        check({31'h0, ctrl4_o[10]}, 32'h1);
        op(3'h1, 1'b0, 32'h0, 2'b10, XM);
        op(3'h4, 1'b0, 32'h0, 2'b10, XM);
        op(3'h1, 1'b0, 32'h0, 2'b11, OK);
    endtask
    task automatic t_irq();
        rd_chk(12'h00C, 32'h0000_0007);
        irq_chk(1'b0);
        wr(12'h010, 32'h0000_0002);
        irq_chk(1'b1);
        rd_chk(12'h010, 32'h0000_0002);
        wr(12'h014, 32'h0000_0002);
        irq_chk(1'b0);
        rd_chk(12'h00C, 32'h0000_0005);
        // low clock enable freezes the status bits
        @(posedge clk_i) ce_i <= 1'b0;
        wr(12'h014, 32'h0000_0007);
        @(posedge clk_i) ce_i <= 1'b1;
        rd_chk(12'h00C, 32'h0000_0005);
        rd_chk(12'h014, 32'h0000_0000);
        wr(12'h014, 32'h0000_0007);
        rd_chk(12'h00C, 32'h0000_0000);
    endtask
    initial begin
        {rst_i, ce_i, hw_wide_i, hw_save_i, hw_cipher_i} = 5'h1F;
        {psel_i, penable_i, pwrite_i, hw_clmul_i} = 4'h0;
        {dec_valid_i, dec_priv0_i, dec_fp_exc_i, dec_fp_masked_i} = 4'h0;
        {paddr_i, pwdata_i, dec_wdata_i, dec_class_i} = 79'h0;
        {err_count, n_checks, cycles} = 96'h0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_leaf1();
        t_gating();
        t_ctrl_wr();
        t_fp();
        t_irq();
        end_of_test();
    end
endmodule
bind vext_enable_gating vext_enable_gating_asserts u_vext_enable_gating_asserts (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pslverr_o(pslverr_o), .dec_valid_i(dec_valid_i),
    .dec_class_i(dec_class_i), .dec_priv0_i(dec_priv0_i),
    .dec_fp_exc_i(dec_fp_exc_i), .dec_fp_masked_i(dec_fp_masked_i),
    .dec_ud_o(dec_ud_o), .dec_gp_o(dec_gp_o), .dec_emul_o(dec_emul_o),
    .dec_xm_o(dec_xm_o), .dec_commit_o(dec_commit_o),
    .dec_rdata_o(dec_rdata_o), .id_leaf1_o(id_leaf1_o),
    .ctrl4_o(ctrl4_o));
`default_nettype wire
